// ---- phy_mgmt_pkg.sv ----
// What this block does
// - Disable input high ignores all serial transactions
// - Config pins load only register defaults
// - After reset, serial channel controls those bits
// - Shared data line, each side drives own part
// - Interrupt enable set: drive interrupt low on change
// - Reading interrupt status clears and releases interrupt
// - Answer only frames matching strapped address
// - Reset pin ORed with soft bit, extended
package phy_mgmt_pkg;

  // Clock and reset extension timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_EXT_NS    = 258000;
  localparam int RST_EXT_CYC   = RST_EXT_NS / CLK_PERIOD_NS;

  // Serial frame layout
  localparam int PREAMBLE_MIN = 32;
  localparam int HDR_BITS     = 12;
  localparam int TA_BITS      = 2;
  localparam int DATA_BITS    = 16;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // Serial register numbers and fields
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_INT_EN   = 5'h12;
  localparam logic [4:0] REG_INT_STAT = 5'h13;
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_CFG3_BIT  = 13;
  localparam int CTRL_CFG2_BIT  = 12;
  localparam int CTRL_CFG1_BIT  = 8;
  localparam int INT_EN_BIT     = 1;
  localparam int INT_PEND_BIT   = 2;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] INT_EN_RST = 16'h0000;
  localparam logic [3:0]  PHY_ADDR_HI_DEF = 4'h0;

  // Bus register byte addresses and fields
  localparam logic [7:0] BUS_EVENT   = 8'h00;
  localparam logic [7:0] BUS_STATUS  = 8'h04;
  localparam logic [7:0] BUS_CTRL    = 8'h08;
  localparam logic [7:0] BUS_INT_EN  = 8'h0C;
  localparam int EVT_CHANGE_BIT = 0;
  localparam int ST_BUSY_BIT    = 5;
  localparam int ST_PEND_BIT    = 6;
  localparam int ST_DIS_BIT     = 7;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Pins from outside the clock domain
  typedef struct packed {
    logic       mdc;
    logic       mdio;
    logic       disable_n;
    logic       rst_n;
    logic       strap;
    logic [2:0] cfg;
  } pins_t;

  // Bus address phase as captured
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } bus_req_t;

  // Decoded serial frame header
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } frame_hdr_t;

endpackage : phy_mgmt_pkg

// ---- phy_rst_extend.sv ----
`timescale 1ns/1ps
module phy_rst_extend #(
  parameter int EXT_CYCLES = phy_mgmt_pkg::RST_EXT_CYC
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Reset sources
  input  wire logic hw_rst,
  input  wire logic sw_rst,
  // Reset cycle active
  output logic      busy
);
  import phy_mgmt_pkg::*;

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_busy;

  // Pin and soft bit combine; count restarts after both drop
  always_comb begin
    next_cnt  = cnt;
    next_busy = busy;
    if (hw_rst || sw_rst) begin
      next_cnt  = 32'(EXT_CYCLES);
      next_busy = 1'b1;
    end else if (cnt != 32'h0) begin
      next_cnt  = cnt - 32'h1;
    end else begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 32'(EXT_CYCLES);
      busy <= 1'b1;
    end else begin
      cnt  <= next_cnt;
      busy <= next_busy;
    end
  end

  property p_rst_extend;
    @(posedge hclk) disable iff (!hresetn)
      $fell(hw_rst || sw_rst) |-> busy [*8];
  endproperty
  a_rst_extend: assert property (p_rst_extend) else $error("reset cycle ended early");

endmodule : phy_rst_extend

// ---- phy_mgmt_port_ctrl.sv ----
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module phy_mgmt_port_ctrl #(
  parameter int         RST_EXT_CYCLES = phy_mgmt_pkg::RST_EXT_CYC,
  parameter logic [3:0] PHY_ADDR_HI    = phy_mgmt_pkg::PHY_ADDR_HI_DEF
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Serial management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Interrupt pin, open drain
  output logic             mgmt_irq_n_out,
  output logic             mgmt_irq_n_oe,
  // Straps and configuration pins
  input  wire logic        mgmt_access_disable,
  input  wire logic        phy_reset_n,
  input  wire logic        phy_addr_strap0,
  input  wire logic [2:0]  cfg_pin
);
  import phy_mgmt_pkg::*;

  typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA} fsm_t;

  pins_t pins_raw, sync1, sync2;
  logic  mdc_d;
  logic  busy;
  logic  sw_rst;

  assign pins_raw = '{mdc: mdc, mdio: mdio_in, disable_n: ~mgmt_access_disable,
                      rst_n: phy_reset_n, strap: phy_addr_strap0, cfg: cfg_pin};

  // Two-flop synchroniser for every outside pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      mdc_d <= 1'b0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      mdc_d <= sync2.mdc;
    end
  end

  wire logic mdc_rise = sync2.mdc & ~mdc_d;
  wire logic mgmt_off = ~sync2.disable_n;

  phy_rst_extend #(
    .EXT_CYCLES(RST_EXT_CYCLES)
  ) phy_rst_extend_i (
    .hclk   (hclk),
    .hresetn(hresetn),
    .hw_rst (~sync2.rst_n),
    .sw_rst (sw_rst),
    .busy   (busy)
  );

  // Serial engine and management register state
  fsm_t        state, next_state;
  logic [5:0]  cnt, next_cnt;
  logic [15:0] shift, next_shift;
  frame_hdr_t  hdr, next_hdr;
  logic [4:0]  phy_addr, next_phy_addr;
  logic [15:0] ctrl, next_ctrl;
  logic [15:0] int_en, next_int_en;
  logic        pend, next_pend;
  logic        next_mdio_out, next_mdio_oe, next_irq_oe;
  logic        evt_set, next_sw_rst;
  logic        rd_clear;

  function automatic logic [15:0] reg_read(input logic [4:0] ra, input logic [15:0] c,
                                            input logic [15:0] e, input logic p,
                                            input logic b);
    logic [15:0] v;
    v = 16'h0000;
    case (ra)
      REG_CTRL:     begin v = c; v[CTRL_RESET_BIT] = b; end
      REG_INT_EN:   v = e;
      REG_INT_STAT: v[INT_PEND_BIT] = p;
      default:      v = 16'h0000;
    endcase
    return v;
  endfunction : reg_read

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_shift    = shift;
    next_hdr      = hdr;
    next_phy_addr = phy_addr;
    next_ctrl     = ctrl;
    next_int_en   = int_en;
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    next_sw_rst   = 1'b0;
    rd_clear      = 1'b0;
    if (busy) begin
      // Pins give defaults and the address while the reset cycle runs
      next_phy_addr = {PHY_ADDR_HI, sync2.strap};
      next_ctrl     = CTRL_RST;
      next_ctrl[CTRL_CFG3_BIT] = sync2.cfg[2];
      next_ctrl[CTRL_CFG2_BIT] = sync2.cfg[1];
      next_ctrl[CTRL_CFG1_BIT] = sync2.cfg[0];
      next_int_en   = INT_EN_RST;
      next_state    = S_PRE;
      next_cnt      = '0;
      next_mdio_oe  = 1'b0;
    end else if (mgmt_off) begin
      // Channel disabled: release the line, drop any frame
      next_state   = S_PRE;
      next_cnt     = '0;
      next_mdio_oe = 1'b0;
    end else if (mdc_rise) begin
      case (state)
        S_PRE: begin
          if (sync2.mdio) begin
            next_cnt = (cnt == 6'(PREAMBLE_MIN)) ? cnt : cnt + 6'h1;
          end else if (cnt == 6'(PREAMBLE_MIN)) begin
            next_state = S_ST;
          end else begin
            next_cnt = '0;
          end
        end
        S_ST: begin
          next_state = sync2.mdio ? S_HDR : S_PRE;
          next_cnt   = '0;
        end
        S_HDR: begin
          next_shift = {shift[14:0], sync2.mdio};
          next_cnt   = cnt + 6'h1;
          if (cnt == 6'(HDR_BITS - 1)) begin
            next_hdr = frame_hdr_t'({shift[10:0], sync2.mdio});
            next_cnt = '0;
            // Only frames addressed to this device go on
            if (next_hdr.phy == phy_addr &&
                (next_hdr.op == OP_READ || next_hdr.op == OP_WRITE)) begin
              next_state = S_TA;
              if (next_hdr.op == OP_READ) begin
                next_shift = reg_read(next_hdr.regad, ctrl, int_en, pend, busy);
                rd_clear   = (next_hdr.regad == REG_INT_STAT);
              end
            end else begin
              next_state = S_PRE;
            end
          end
        end
        S_TA: begin
          next_cnt = cnt + 6'h1;
          if (hdr.op == OP_READ && cnt == 6'h0) begin
            next_mdio_oe  = 1'b1;
            next_mdio_out = 1'b0;
          end
          if (cnt == 6'(TA_BITS - 1)) begin
            next_state = S_DATA;
            next_cnt   = '0;
            if (hdr.op == OP_READ) begin
              next_mdio_out = shift[15];
              next_shift    = {shift[14:0], 1'b0};
            end
          end
        end
        S_DATA: begin
          next_cnt = cnt + 6'h1;
          if (hdr.op == OP_READ) begin
            next_mdio_out = shift[15];
            next_shift    = {shift[14:0], 1'b0};
          end else begin
            next_shift = {shift[14:0], sync2.mdio};
          end
          if (cnt == 6'(DATA_BITS - 1)) begin
            next_state   = S_PRE;
            next_cnt     = '0;
            next_mdio_oe = 1'b0;
            if (hdr.op == OP_WRITE) begin
              // Serial channel now owns the configuration bits
              case (hdr.regad)
                REG_CTRL: begin
                  next_ctrl   = next_shift;
                  next_sw_rst = next_shift[CTRL_RESET_BIT];
                end
                REG_INT_EN: next_int_en = next_shift;
                default:    next_int_en = int_en;
              endcase
            end
          end
        end
        default: next_state = S_PRE;
      endcase
    end
    // Status change wins over a clearing read in the same cycle
    next_pend   = evt_set ? 1'b1 : (rd_clear ? 1'b0 : pend);
    if (busy) begin
      next_pend = 1'b0;
    end
    // Pin follows the registered flag and enable one edge later
    next_irq_oe = int_en[INT_EN_BIT] & pend;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state          <= S_PRE;
      cnt            <= '0;
      shift          <= '0;
      hdr            <= '0;
      phy_addr       <= '0;
      ctrl           <= CTRL_RST;
      int_en         <= INT_EN_RST;
      pend           <= 1'b0;
      mdio_out       <= 1'b0;
      mdio_oe        <= 1'b0;
      mgmt_irq_n_oe  <= 1'b0;
      mgmt_irq_n_out <= 1'b0;
      sw_rst         <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      shift          <= next_shift;
      hdr            <= next_hdr;
      phy_addr       <= next_phy_addr;
      ctrl           <= next_ctrl;
      int_en         <= next_int_en;
      pend           <= next_pend;
      mdio_out       <= next_mdio_out;
      mdio_oe        <= next_mdio_oe;
      mgmt_irq_n_oe  <= next_irq_oe;
      mgmt_irq_n_out <= 1'b0;
      sw_rst         <= next_sw_rst;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  bus_req_t req, next_req;
  logic [31:0] next_hrdata;
  wire logic take = hsel & hready & htrans[1];

  always_comb begin
    next_req    = '0;
    next_hrdata = 32'h0000_0000;
    if (take) begin
      next_req = '{wr: hwrite, rd: ~hwrite, addr: haddr[7:0]};
      if (!hwrite) begin
        case (haddr[7:0])
          BUS_STATUS: next_hrdata = {24'h0, mgmt_off, pend, busy, phy_addr};
          BUS_CTRL:   next_hrdata = {16'h0, reg_read(REG_CTRL, ctrl, int_en, pend, busy)};
          BUS_INT_EN: next_hrdata = {16'h0, int_en};
          default:    next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end
  assign evt_set = req.wr && req.addr == BUS_EVENT && hwdata[EVT_CHANGE_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req       <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      req       <= next_req;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Checks
  property p_disable_quiet;
    @(posedge hclk) disable iff (!hresetn) mgmt_off [*2] |-> !mdio_oe && state == S_PRE;
  endproperty
  a_disable_quiet: assert property (p_disable_quiet) else $error("active while disabled");

  property p_cfg_load;
    @(posedge hclk) disable iff (!hresetn) busy [*2] |-> ctrl[CTRL_CFG1_BIT] == $past(sync2.cfg[0]);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config default not loaded");

  property p_cfg_hold;
    @(posedge hclk) disable iff (!hresetn)
      !busy && !$past(busy) && !(mdc_rise && state == S_DATA) ##1 1'b1 |-> $stable(ctrl);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config bits changed without write");

  property p_line_owner;
    @(posedge hclk) disable iff (!hresetn) mdio_oe |-> hdr.op == OP_READ && state inside {S_TA, S_DATA};
  endproperty
  a_line_owner: assert property (p_line_owner) else $error("line driven outside read");

  property p_irq_drive;
    @(posedge hclk) disable iff (!hresetn)
      pend && int_en[INT_EN_BIT] && !busy |=> mgmt_irq_n_oe && !mgmt_irq_n_out;
  endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("interrupt not driven");

  property p_irq_clear;
    @(posedge hclk) disable iff (!hresetn) rd_clear && !evt_set |=> !pend ##1 !mgmt_irq_n_oe;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status read did not clear");

  property p_addr_match;
    @(posedge hclk) disable iff (!hresetn) $rose(state == S_TA) |-> hdr.phy == phy_addr;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("foreign address accepted");

  property p_rise_only;
    @(posedge hclk) disable iff (!hresetn) !mdc_rise && !busy && !mgmt_off |=> $stable(state);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("frame moved without clock rise");

  property p_soft_reset;
    @(posedge hclk) disable iff (!hresetn) sw_rst |=> busy [*4];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not extended");

endmodule : phy_mgmt_port_ctrl

// ---- mgmt_station.sv ----
`timescale 1ns/1ps
module mgmt_station (
  // Clock
  input  wire logic hclk,
  // Shared data line as resolved
  input  wire logic line,
  // Station drive of clock and data
  output logic      mdc,
  output logic      sd,
  output logic      soe
);
  import phy_mgmt_pkg::*;

  // Half period in hclk cycles, 10 gives the 160 ns clock
  int half = 10;

  // Clock stands low and line is released outside frames
  initial begin
    mdc = 1'b0;
    sd  = 1'b0;
    soe = 1'b0;
  end

  // One bit: data set while clock is low, line sampled at the rise
  task slot(input logic b, input logic drv, output logic seen);
    mdc <= 1'b0;
    sd  <= b;
    soe <= drv;
    repeat (half) @(posedge hclk);
    seen = line;
    mdc <= 1'b1;
    repeat (half) @(posedge hclk);
  endtask : slot

  // Whole frame; on reads the line is released from the first turnaround bit
  task frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
             input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hFFFF_FFFF, 2'b01, op, phy, ra};
    for (int i = 45; i >= 0; i--) slot(hdr[i], 1'b1, s);
    slot(1'b1, op == OP_WRITE, s);
    slot(1'b0, op == OP_WRITE, ta);
    for (int i = 15; i >= 0; i--) begin
      slot(wd[i], op == OP_WRITE, s);
      rd[i] = s;
    end
    mdc <= 1'b0;
    soe <= 1'b0;
    // Let one edge pass so a following frame never re-drives in this step
    @(posedge hclk);
  endtask : frame
endmodule : mgmt_station

// ---- phy_mgmt_port_ctrl_tb.sv ----
`timescale 1ns/1ps
module phy_mgmt_port_ctrl_tb;
  import phy_mgmt_pkg::*;
  localparam int         EXT = 20;
  localparam logic [3:0] HI  = 4'h3;
  localparam logic [4:0] ME  = {HI, 1'b1};
  localparam logic [4:0] ALT = {HI, 1'b0};

  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cfg_pin;
  logic        mdc, mdio_out, mdio_oe, sd, soe, mdio_line, irq_out, irq_oe, irq_line;
  logic        dis, prst_n, strap;
  int          bad_count, n_compared, cyc;

  phy_mgmt_port_ctrl #(.RST_EXT_CYCLES(EXT), .PHY_ADDR_HI(HI)) phy_mgmt_port_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mdc(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .mgmt_irq_n_out(irq_out), .mgmt_irq_n_oe(irq_oe), .mgmt_access_disable(dis),
    .phy_reset_n(prst_n), .phy_addr_strap0(strap), .cfg_pin(cfg_pin));
  mgmt_station mgmt_station_i (.hclk(hclk), .line(mdio_line), .mdc(mdc), .sd(sd), .soe(soe));

  // Single slave ready loop, pulled-up data line and interrupt pin
  assign hready    = hreadyout;
  assign mdio_line = mdio_oe ? mdio_out : (soe ? sd : 1'b1);
  assign irq_line  = irq_oe ? irq_out : 1'b1;

  // Clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Counts and verdict
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // One AHB-Lite single word transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task bus_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask : bus_rd

  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : bus_wr

  // Status word: disabled, pending, busy, address
  function automatic logic [31:0] st(input logic d, input logic p, input logic b);
    return {24'h0, d, p, b, ME};
  endfunction : st

  // Serial frames through the station model
  task sread(input logic [4:0] phy, input logic [4:0] ra, input logic eta, input logic [15:0] e);
    logic [15:0] d;
    logic        ta;
    mgmt_station_i.frame(OP_READ, phy, ra, 16'h0, d, ta);
    chk({15'h0, ta, d}, {15'h0, eta, e});
  endtask : sread

  task swrite(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    logic        ta;
    mgmt_station_i.frame(OP_WRITE, phy, ra, wd, d, ta);
  endtask : swrite

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // Poll until the reset cycle is over
  task wait_idle;
    logic [31:0] v;
    int          n;
    n = 0;
    do begin
      bus(1'b0, BUS_STATUS, 32'h0, v);
      n++;
    end while (v[ST_BUSY_BIT] !== 1'b0 && n < 200);
  endtask : wait_idle

  // Hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      finish_test;
    end
  end

  // Both parties must never drive the line together
  always @(posedge hclk) if (soe === 1'b1 && mdio_oe !== 1'b0 && hresetn) chk(32'h1, 32'h0);

  // Main sequence
  initial begin
    logic [15:0] d;
    logic        ta;
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; cfg_pin = 3'b101; dis = 1'b0; prst_n = 1'b1;
    strap = 1'b1;
    bad_count = 0; n_compared = 0; cyc = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // Let the pin synchronisers fill before the first look
    tick(5);
    // Reset cycle loads pins and strap, then serial control takes over
    bus_rd(BUS_STATUS, st(1'b0, 1'b0, 1'b1));
    bus_rd(BUS_CTRL, 32'h0000_A100);
    wait_idle;
    bus_rd(BUS_CTRL, 32'h0000_2100);
    cfg_pin <= 3'b010;
    bus_rd(BUS_CTRL, 32'h0000_2100);
    swrite(ME, REG_CTRL, 16'h1000);
    bus_rd(BUS_CTRL, 32'h0000_1000);
    sread(ME, REG_CTRL, 1'b0, 16'h1000);
    mgmt_station_i.half = 30;
    sread(ME, REG_CTRL, 1'b0, 16'h1000);
    mgmt_station_i.half = 10;
    // Neighbouring address is not answered
    swrite(ALT, REG_CTRL, 16'h0100);
    sread(ALT, REG_CTRL, 1'b1, 16'hFFFF);
    bus_rd(BUS_CTRL, 32'h0000_1000);
    // Unknown opcode is dropped and the line stays released
    mgmt_station_i.frame(2'h3, ME, REG_CTRL, 16'h0100, d, ta);
    chk({31'h0, ta}, 32'h1);
    bus_rd(BUS_CTRL, 32'h0000_1000);
    // Event with interrupt off: pends, pin stays high
    bus_wr(BUS_EVENT, 32'h1);
    tick(4);
    chk({31'h0, irq_line}, 32'h1);
    bus_rd(BUS_STATUS, st(1'b0, 1'b1, 1'b0));
    sread(ME, REG_INT_STAT, 1'b0, 16'h0004);
    bus_rd(BUS_STATUS, st(1'b0, 1'b0, 1'b0));
    // Event with interrupt on: pin low until status is read
    swrite(ME, REG_INT_EN, 16'h0002);
    bus_rd(BUS_INT_EN, 32'h2);
    bus_wr(BUS_EVENT, 32'h1);
    tick(4);
    chk({31'h0, irq_line}, 32'h0);
    sread(ME, REG_INT_STAT, 1'b0, 16'h0004);
    chk({31'h0, irq_line}, 32'h1);
    sread(ME, REG_INT_STAT, 1'b0, 16'h0000);
    // Disabled channel ignores frames
    dis <= 1'b1;
    tick(4);
    bus_rd(BUS_STATUS, st(1'b1, 1'b0, 1'b0));
    swrite(ME, REG_CTRL, 16'h0100);
    sread(ME, REG_CTRL, 1'b1, 16'hFFFF);
    bus_rd(BUS_CTRL, 32'h0000_1000);
    dis <= 1'b0;
    tick(4);
    // Pin reset reloads pins and the strapped address
    cfg_pin <= 3'b100;
    strap   <= 1'b0;
    prst_n  <= 1'b0;
    tick(5);
    prst_n <= 1'b1;
    bus_rd(BUS_STATUS, {24'h0, 3'b001, ALT});
    wait_idle;
    bus_rd(BUS_CTRL, 32'h0000_2000);
    bus_rd(BUS_INT_EN, 32'h0);
    sread(ALT, REG_CTRL, 1'b0, 16'h2000);
    sread(ME, REG_CTRL, 1'b1, 16'hFFFF);
    // Soft reset bit restarts the reset cycle and retakes the strap
    cfg_pin <= 3'b011;
    strap   <= 1'b1;
    swrite(ALT, REG_CTRL, 16'h8000);
    bus_rd(BUS_STATUS, st(1'b0, 1'b0, 1'b1));
    wait_idle;
    bus_rd(BUS_CTRL, 32'h0000_1100);
    // Unmapped offset reads zero and ignores writes
    bus_wr(8'h10, 32'hFFFF_FFFF);
    bus_rd(8'h10, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    finish_test;
  end
endmodule : phy_mgmt_port_ctrl_tb
